// >>> rtl/amp_regs_consts.svh
// amp_regs_consts.svh: addresses, field positions, reset values and counts
// assumes: included by bare name from the register bank, the host model and the bench
`ifndef AMP_REGS_CONSTS_SVH
`define AMP_REGS_CONSTS_SVH

// register addresses on the control port
`define ADDR_SHUTDOWN_FLAGS 8'h12
`define ADDR_WARN_FLAGS 8'h13
`define ADDR_PIN_MASK 8'h14
`define ADDR_AC_ENABLE_GAIN 8'h15
`define ADDR_AC_MEASURE_LENGTH_SEL_CURRENT 8'h16

// reset values
`define RST_WARN_FLAGS 8'h20
`define RST_PIN_MASK 8'h00
`define RST_AC_ENABLE_GAIN 8'h00
`define RST_AC_MEASURE_LENGTH_SEL_CURRENT 8'h00

// field positions
`define BIT_GLOBAL_FLAG 4
`define BIT_POR_FLAG 5
`define BIT_OVERCURRENT_ALERT_MASK 7
`define BIT_SHUTDOWN_ALERT_MASK 6
`define BIT_UNDERVOLT_ALERT_MASK 5
`define BIT_OVERVOLT_ALERT_MASK 4
`define BIT_DC_OFFSET_ALERT_MASK 3
`define BIT_MASK_ILIMIT 2
`define BIT_MASK_CLIP 1
`define BIT_THERMAL_WARN_MASK 0
`define BIT_GAIN_ONE_TWO 7
`define BIT_GAIN_THREE_FOUR 5
`define BIT_LOOPBACK 7
`define BIT_MEAS_LEN 4
`define BIT_CURRENT_HI 3
`define BIT_CURRENT_LO 2

// writable bits; reserved bits are dropped on write and read zero
`define WMASK_AC_ENABLE_GAIN 8'haf
`define WMASK_AC_MEASURE_LENGTH_SEL_CURRENT 8'h9c

// measurement lengths in cycles
`define MEAS_CYCLES_SHORT 7'h20
`define MEAS_CYCLES_LONG 7'h40

// impedance result step, in micro-ohm per count
`define AC_IMP_STEP_UOHM 249600

`endif

// >>> rtl/amp_regs_pkg.sv
// amp_regs_pkg.sv: types shared by the fault, warning and ac-check registers
// assumes: constants come from amp_regs_consts.svh
package amp_regs_pkg;
  typedef logic [7:0] reg_byte_type;
  typedef logic [3:0] chan_vec_type;
  typedef enum logic [1:0] {
    CUR_10MA = 2'h0,
    CUR_19MA = 2'h1,
    CUR_RSVD_A = 2'h2,
    CUR_RSVD_B = 2'h3
  } ac_test_current_sel_type;
endpackage

// >>> rtl/amp_fault_warn_acdiag_regs.sv
// amp_fault_warn_acdiag_regs.sv: thermal status, alert masks and ac-check setup
// assumes: status inputs synchronous to core_clk; host port decoded upstream
// Overview of operation
// - bit 4 of shutdown flags shows live device-wide thermal shutdown.
// - shutdown flags bits 3..0 show channel one..four thermal shutdown.
// - warning register bit 5 becomes 1 after a logic-supply power-on reset.
// - warning register at 0x13 reads 0x20 after reset.
// - warning register bit 4 shows live device-level thermal warning.
// - warning register bits 3..0 show channel one..four thermal warnings.
// - pin mask bit 7 set keeps overcurrent off the fault pin.
// - pin mask bit 6 set keeps thermal shutdown off the fault pin.
// - pin mask bits 5 and 4 gate undervoltage and overvoltage to fault pin.
// - pin mask bits 3 and 2 gate dc-offset and current limit to fault pin.
// - pin mask bit 1 set keeps clipping off the warning pin.
// - pin mask bit 0 set keeps thermal warnings off the warning pin.
// - pin mask register at 0x14 resets to 0x00, all classes reported.
// - ac control one bit 7 picks gain 1 or 4 for channels one, two.
// - ac control one bit 5 picks gain 1 or 4 for channels three, four.
// - ac control one bits 3..0 enable ac check on channels one..four.
// - ac control two bit 7 enables the ac check loopback path.
// - ac control two bit 4 picks 32 or 64 measurement cycles.
// - ac control two bits 3..2 pick 10 mA or 19 mA; host avoids 10, 11.
// - ac control registers at 0x15 and 0x16 reset to 0x00.
// - ac results are 8-bit impedance codes set up by both ac registers.
`timescale 1ns/1ps
`default_nettype none
`include "amp_regs_consts.svh"

module amp_fault_warn_acdiag_regs
  import amp_regs_pkg::*;
(
  input wire logic core_clk, // system clock, 100 MHz
  input wire logic rst, // synchronous reset, high; also the supply power-on reset
  input wire logic [7:0] reg_addr, // register address
  input wire logic reg_wr, // write strobe, one cycle
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_rd, // read strobe, one cycle
  output logic [7:0] reg_rdata, // read data, valid with reg_rvalid
  output logic reg_rvalid, // read answer pulse
  input wire logic global_thermal_shutdown, // device-wide shutdown level
  input wire logic [3:0] chan_thermal_shutdown, // bit 3 channel one
  input wire logic global_thermal_warning, // device-level warning level
  input wire logic [3:0] chan_thermal_warning, // bit 3 channel one
  input wire logic overcurrent_fault, // any overcurrent fault present
  input wire logic undervolt_fault, // any undervoltage fault present
  input wire logic overvolt_fault, // any overvoltage fault present
  input wire logic dc_offset_fault, // any dc-offset fault present
  input wire logic current_limit_event, // current limit active
  input wire logic clipping_event, // clipping detected
  input wire logic por_flag_clear, // pulse from fault-clear logic
  output logic fault_alert_n, // fault pin, low active
  output logic warn_alert_n, // warning pin, low active
  output logic [3:0] chan_ac_check_en, // ac check enables, bit 3 channel one
  output logic paralleled_pair_one_two_gain, // 1 selects gain 4
  output logic paralleled_pair_three_four_gain, // 1 selects gain 4
  output logic ac_check_loopback_en, // loopback path enable
  output logic ac_measure_length_sel, // 0: 32 cycles, 1: 64 cycles
  output logic [6:0] ac_measure_cycles, // measurement length as a count
  output ac_test_current_sel_type ac_test_current_sel // test current code
);

  // status state
  logic [4:0] tsd_ff;
  logic [4:0] nxt_tsd;
  logic [4:0] warn_ff;
  logic [4:0] nxt_warn;
  logic por_ff;
  logic nxt_por;

  // control state
  reg_byte_type mask_ff;
  reg_byte_type nxt_mask;
  reg_byte_type acd1_ff;
  reg_byte_type nxt_acd1;
  reg_byte_type acd2_ff;
  reg_byte_type nxt_acd2;
  logic [6:0] cycles_ff;
  logic [6:0] nxt_cycles;

  // pins and read port
  logic fault_n_ff;
  logic nxt_fault_n;
  logic warn_n_ff;
  logic nxt_warn_n;
  reg_byte_type rdata_ff;
  reg_byte_type nxt_rdata;
  logic rvalid_ff;
  logic nxt_rvalid;

  // combined class levels before masking
  logic any_tsd;
  logic any_otw;
  logic [5:0] fault_class;
  logic [5:0] fault_mask;
  logic [1:0] warn_class;
  logic [1:0] warn_mask;

  // thermal flags are live copies; the analog side owns latching and recovery; the power-on flag holds until por_flag_clear
  always_comb
  begin
    nxt_tsd = {global_thermal_shutdown, chan_thermal_shutdown};
    nxt_warn = {global_thermal_warning, chan_thermal_warning};
    nxt_por = por_ff & ~por_flag_clear;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      tsd_ff <= 5'h00;
      warn_ff <= 5'h00;
      por_ff <= 1'b1;
    end
    else
    begin
      tsd_ff <= nxt_tsd;
      warn_ff <= nxt_warn;
      por_ff <= nxt_por;
    end
  end

  // control writes; reserved bits are stripped so they always read zero
  always_comb
  begin
    nxt_mask = mask_ff;
    nxt_acd1 = acd1_ff;
    nxt_acd2 = acd2_ff;
    if (reg_wr)
    begin
      case (reg_addr)
        `ADDR_PIN_MASK: nxt_mask = reg_wdata;
        `ADDR_AC_ENABLE_GAIN: nxt_acd1 = reg_wdata & `WMASK_AC_ENABLE_GAIN;
        `ADDR_AC_MEASURE_LENGTH_SEL_CURRENT: nxt_acd2 = reg_wdata & `WMASK_AC_MEASURE_LENGTH_SEL_CURRENT;
        default: ;
      endcase
    end
    // length count is loaded from the next select bit, so it changes on the same edge as the register
    nxt_cycles = nxt_acd2[`BIT_MEAS_LEN] ? `MEAS_CYCLES_LONG : `MEAS_CYCLES_SHORT;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      mask_ff <= `RST_PIN_MASK;
      acd1_ff <= `RST_AC_ENABLE_GAIN;
      acd2_ff <= `RST_AC_MEASURE_LENGTH_SEL_CURRENT;
      cycles_ff <= `MEAS_CYCLES_SHORT;
    end
    else
    begin
      mask_ff <= nxt_mask;
      acd1_ff <= nxt_acd1;
      acd2_ff <= nxt_acd2;
      cycles_ff <= nxt_cycles;
    end
  end

  // class gating: pins follow the raw inputs so they line up with the flags
  always_comb
  begin
    any_tsd = global_thermal_shutdown | (|chan_thermal_shutdown);
    any_otw = global_thermal_warning | (|chan_thermal_warning);
    fault_class = {overcurrent_fault, any_tsd, undervolt_fault, overvolt_fault,
                   dc_offset_fault, current_limit_event};
    fault_mask = mask_ff[`BIT_OVERCURRENT_ALERT_MASK:`BIT_MASK_ILIMIT];
    warn_class = {clipping_event, any_otw};
    warn_mask = mask_ff[`BIT_MASK_CLIP:`BIT_THERMAL_WARN_MASK];
    nxt_fault_n = ~(|(fault_class & ~fault_mask));
    nxt_warn_n = ~(|(warn_class & ~warn_mask));
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      fault_n_ff <= 1'b1;
      warn_n_ff <= 1'b1;
    end
    else
    begin
      fault_n_ff <= nxt_fault_n;
      warn_n_ff <= nxt_warn_n;
    end
  end

  // read mux; unmapped addresses answer 0x00, reads have no side effects
  always_comb
  begin
    nxt_rvalid = reg_rd;
    nxt_rdata = rdata_ff;
    if (reg_rd)
    begin
      case (reg_addr)
        `ADDR_SHUTDOWN_FLAGS: nxt_rdata = {3'h0, tsd_ff};
        `ADDR_WARN_FLAGS: nxt_rdata = {2'h0, por_ff, warn_ff};
        `ADDR_PIN_MASK: nxt_rdata = mask_ff;
        `ADDR_AC_ENABLE_GAIN: nxt_rdata = acd1_ff;
        `ADDR_AC_MEASURE_LENGTH_SEL_CURRENT: nxt_rdata = acd2_ff;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  // outputs straight from flops; ac setup feeds the impedance measurement
  assign reg_rdata = rdata_ff;
  assign reg_rvalid = rvalid_ff;
  assign fault_alert_n = fault_n_ff;
  assign warn_alert_n = warn_n_ff;
  assign chan_ac_check_en = acd1_ff[3:0];
  assign paralleled_pair_one_two_gain = acd1_ff[`BIT_GAIN_ONE_TWO];
  assign paralleled_pair_three_four_gain = acd1_ff[`BIT_GAIN_THREE_FOUR];
  assign ac_check_loopback_en = acd2_ff[`BIT_LOOPBACK];
  assign ac_measure_length_sel = acd2_ff[`BIT_MEAS_LEN];
  assign ac_measure_cycles = cycles_ff;
  // reserved codes are passed on as written; the host must not use them
  assign ac_test_current_sel = ac_test_current_sel_type'(acd2_ff[`BIT_CURRENT_HI:`BIT_CURRENT_LO]);

  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  tsd_global_a: assert property (!$past(rst) |-> tsd_ff[4] == $past(global_thermal_shutdown))
    else $error("global shutdown flag does not follow its input");

  tsd_chan_a: assert property (!$past(rst) |-> tsd_ff[3:0] == $past(chan_thermal_shutdown))
    else $error("channel shutdown flags out of order");

  por_hold_a: assert property (por_ff && !por_flag_clear |=> por_ff)
    else $error("power-on flag lost without a clear");

  warn_reset_a: assert property ($past(rst) |-> por_ff && warn_ff == 5'h00)
    else $error("warning register not 0x20 after reset");

  warn_flags_a: assert property (!$past(rst) |->
    warn_ff == $past({global_thermal_warning, chan_thermal_warning}))
    else $error("warning flags do not follow inputs");

  oc_masked_a: assert property (mask_ff[`BIT_OVERCURRENT_ALERT_MASK]
    && !(|({any_tsd, undervolt_fault, overvolt_fault, dc_offset_fault,
    current_limit_event} & ~mask_ff[`BIT_SHUTDOWN_ALERT_MASK:`BIT_MASK_ILIMIT])) |=> fault_alert_n)
    else $error("masked overcurrent reached fault pin");

  fault_pin_a: assert property (!$past(rst) |-> fault_alert_n ==
    !$past(|({overcurrent_fault, global_thermal_shutdown | (|chan_thermal_shutdown),
    undervolt_fault, overvolt_fault, dc_offset_fault, current_limit_event}
    & ~mask_ff[7:2])))
    else $error("fault pin disagrees with classes and masks");

  warn_pin_a: assert property (clipping_event && !mask_ff[1] |=> !warn_alert_n)
    else $error("unmasked clipping missing on warning pin");

  otw_pin_a: assert property (!$past(rst) && $past(mask_ff[0]) && !$past(clipping_event)
    |-> warn_alert_n)
    else $error("masked thermal warning reached warning pin");

  mask_write_a: assert property (reg_wr && reg_addr == `ADDR_PIN_MASK
    |=> mask_ff == $past(reg_wdata))
    else $error("pin mask write not stored");

  gain_write_a: assert property (reg_wr && reg_addr == `ADDR_AC_ENABLE_GAIN
    |=> paralleled_pair_one_two_gain == $past(reg_wdata[7])
    && chan_ac_check_en == $past(reg_wdata[3:0]))
    else $error("ac gain or enable write not applied");

  // exact in both directions, so a count stuck at either value is caught
  meas_len_a: assert property (ac_measure_cycles ==
    (ac_measure_length_sel ? `MEAS_CYCLES_LONG : `MEAS_CYCLES_SHORT))
    else $error("measurement length count wrong");

  ac_reset_a: assert property ($past(rst) |-> acd1_ff == 8'h00 && acd2_ff == 8'h00)
    else $error("ac control registers not cleared by reset");

  rd_answer_a: assert property (reg_rd && reg_addr == `ADDR_WARN_FLAGS
    |=> reg_rvalid && reg_rdata[7:6] == 2'h0)
    else $error("warning read answer wrong");

  // each class alone must pull its pin whenever its mask bit is clear
  oc_report_a: assert property (overcurrent_fault && !mask_ff[`BIT_OVERCURRENT_ALERT_MASK]
    |=> !fault_alert_n)
    else $error("unmasked overcurrent missing on fault pin");

  tsd_report_a: assert property (any_tsd && !mask_ff[`BIT_SHUTDOWN_ALERT_MASK]
    |=> !fault_alert_n)
    else $error("unmasked thermal shutdown missing on fault pin");

  tsd_masked_a: assert property (mask_ff[`BIT_SHUTDOWN_ALERT_MASK]
    && !(|({overcurrent_fault, undervolt_fault, overvolt_fault, dc_offset_fault,
    current_limit_event} & ~{mask_ff[`BIT_OVERCURRENT_ALERT_MASK], mask_ff[`BIT_UNDERVOLT_ALERT_MASK:`BIT_MASK_ILIMIT]}))
    |=> fault_alert_n)
    else $error("masked thermal shutdown reached fault pin");

  uv_report_a: assert property (undervolt_fault && !mask_ff[`BIT_UNDERVOLT_ALERT_MASK]
    |=> !fault_alert_n)
    else $error("unmasked undervoltage missing on fault pin");

  ov_report_a: assert property (overvolt_fault && !mask_ff[`BIT_OVERVOLT_ALERT_MASK]
    |=> !fault_alert_n)
    else $error("unmasked overvoltage missing on fault pin");

  dc_report_a: assert property (dc_offset_fault && !mask_ff[`BIT_DC_OFFSET_ALERT_MASK]
    |=> !fault_alert_n)
    else $error("unmasked dc offset missing on fault pin");

  ilim_report_a: assert property (current_limit_event && !mask_ff[`BIT_MASK_ILIMIT]
    |=> !fault_alert_n)
    else $error("unmasked current limit missing on fault pin");

  otw_report_a: assert property (any_otw && !mask_ff[`BIT_THERMAL_WARN_MASK]
    |=> !warn_alert_n)
    else $error("unmasked thermal warning missing on warning pin");

  // control writes land on the outputs at the edge after the strobe
  gain34_write_a: assert property (reg_wr && reg_addr == `ADDR_AC_ENABLE_GAIN
    |=> paralleled_pair_three_four_gain == $past(reg_wdata[`BIT_GAIN_THREE_FOUR]))
    else $error("ac gain for channels three and four not applied");

  acd2_write_a: assert property (reg_wr && reg_addr == `ADDR_AC_MEASURE_LENGTH_SEL_CURRENT
    |=> ac_check_loopback_en == $past(reg_wdata[`BIT_LOOPBACK])
    && ac_measure_length_sel == $past(reg_wdata[`BIT_MEAS_LEN])
    && ac_test_current_sel == $past(reg_wdata[`BIT_CURRENT_HI:`BIT_CURRENT_LO]))
    else $error("ac_measure_length_sel or current write not applied");

  // the power-on flag is read-only: no host write may move it
  ro_write_a: assert property (reg_wr && !por_flag_clear
    |=> por_ff == $past(por_ff))
    else $error("host write changed the power-on flag");

  por_clear_a: assert property (por_flag_clear |=> !por_ff)
    else $error("power-on flag not cleared by its clear pulse");

  fault_seen_c: cover property (!fault_alert_n ##1 fault_alert_n);
  warn_seen_c: cover property (!warn_alert_n);
  ac_setup_c: cover property (reg_wr && reg_addr == `ADDR_AC_MEASURE_LENGTH_SEL_CURRENT
    ##1 ac_measure_length_sel);
  por_cleared_c: cover property (por_ff ##1 !por_ff);

endmodule
`default_nettype wire

// >>> tb/host_model.sv
// host_model.sv: host side of the register port, byte writes and reads
// assumes: one clock; the bank answers a read with reg_rvalid one cycle later
`timescale 1ns/1ps
`default_nettype none
`include "amp_regs_consts.svh"

module host_model
(
  input wire logic core_clk, // system clock
  output logic [7:0] reg_addr, // register address
  output logic reg_wr, // write strobe
  output logic [7:0] reg_wdata, // write data
  output logic reg_rd, // read strobe
  input wire logic [7:0] reg_rdata, // read data
  input wire logic reg_rvalid // read answer
);
  // idle port at time zero
  initial
  begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end

  // released lines go to the inverse so stale values are never trusted
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= (a == `ADDR_AC_MEASURE_LENGTH_SEL_CURRENT) ? (d & 8'hf7) : d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  // no answer in the expected cycle yields unknown data
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
  endtask
endmodule

`default_nettype wire

// >>> tb/amp_fault_warn_acdiag_regs_bench.sv
// amp_fault_warn_acdiag_regs_bench.sv: self-checking bench for the status and mask bank
// assumes: host_model drives the register port; status inputs are driven here
`timescale 1ns/1ps
`default_nettype none
`include "amp_regs_consts.svh"

module amp_fault_warn_acdiag_regs_bench;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] stat = 16'h0000; // shutdown[15:11] warning[10:6] oc uv ov dc ilim clip
  logic por_flag_clear = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, reg_rvalid, fault_alert_n, warn_alert_n, g12, g34, lb, len;
  logic [3:0] ac_en;
  logic [6:0] cyc;
  logic [1:0] cur;
  logic [1:0] e;
  integer seed = 32'h2744547f;
  int err_count = 0;
  int tests_run = 0;

  always #5 core_clk = ~core_clk;

  host_model hm (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  amp_fault_warn_acdiag_regs dut_u (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .global_thermal_shutdown(stat[15]),
    .chan_thermal_shutdown(stat[14:11]), .global_thermal_warning(stat[10]),
    .chan_thermal_warning(stat[9:6]), .overcurrent_fault(stat[5]),
    .undervolt_fault(stat[4]), .overvolt_fault(stat[3]), .dc_offset_fault(stat[2]),
    .current_limit_event(stat[1]), .clipping_event(stat[0]),
    .por_flag_clear(por_flag_clear), .fault_alert_n(fault_alert_n),
    .warn_alert_n(warn_alert_n), .chan_ac_check_en(ac_en),
    .paralleled_pair_one_two_gain(g12), .paralleled_pair_three_four_gain(g34),
    .ac_check_loopback_en(lb), .ac_measure_length_sel(len), .ac_measure_cycles(cyc),
    .ac_test_current_sel(cur));

  task automatic chk_reg(input string nm, input logic [7:0] ex, input logic [7:0] g);
    tests_run++;
    if (g !== ex)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, ex, g);
    end
  endtask

  task automatic chk_pin(input string nm, input logic ex, input logic g);
    tests_run++;
    if (g !== ex)
    begin
      err_count++;
      $display("ERROR %s expected %b seen %b", nm, ex, g);
    end
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] ex);
    logic [7:0] q;
    hm.rd(a, q);
    chk_reg(nm, ex, q);
  endtask

  // pin levels: fault classes on bits 7..2, warning classes on bits 1..0
  function automatic logic [1:0] exp_pins(input logic [15:0] s, input logic [7:0] m);
    logic [7:0] f;
    f = {s[5], |s[15:11], s[4:1], s[0], |s[10:6]};
    return {~|(f[7:2] & ~m[7:2]), ~|(f[1:0] & ~m[1:0])};
  endfunction

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // hang guard, far beyond the roughly 600 cycles the tests need
  initial
  begin
    #200000;
    err_count++;
    give_verdict();
  end

  initial
  begin
    logic [7:0] d;
    logic [7:0] m;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    // reset values, a read-only write and an unmapped read
    rd_chk("warn_rst", `ADDR_WARN_FLAGS, 8'h20);
    rd_chk("mask_rst", `ADDR_PIN_MASK, 8'h00);
    rd_chk("acen_rst", `ADDR_AC_ENABLE_GAIN, 8'h00);
    rd_chk("actc_rst", `ADDR_AC_MEASURE_LENGTH_SEL_CURRENT, 8'h00);
    rd_chk("shut_rst", `ADDR_SHUTDOWN_FLAGS, 8'h00);
    rd_chk("unmapped", 8'h30, 8'h00);
    chk_reg("cyc_rst", 8'h20, {1'b0, cyc});
    hm.wr(`ADDR_WARN_FLAGS, 8'h00);
    rd_chk("warn_ro", `ADDR_WARN_FLAGS, 8'h20);
    @(posedge core_clk);
    por_flag_clear <= 1'b1;
    @(posedge core_clk);
    por_flag_clear <= 1'b0;
    rd_chk("warn_clr", `ADDR_WARN_FLAGS, 8'h00);
    $display("test reset done");
    // one class at a time unmasked then masked, then random mixes
    for (int i = 0; i < 48; i++)
    begin
      m = (i < 16) ? 8'h00 : (i < 32) ? 8'hff : 8'($random(seed));
      hm.wr(`ADDR_PIN_MASK, m);
      @(posedge core_clk);
      stat <= (i < 32) ? (16'h0001 << (i % 16)) : 16'($random(seed));
      @(posedge core_clk);
      #1;
      e = exp_pins(stat, m);
      chk_pin("fault_pin", e[1], fault_alert_n);
      chk_pin("warn_pin", e[0], warn_alert_n);
      rd_chk("shut", `ADDR_SHUTDOWN_FLAGS, {3'h0, stat[15:11]});
      rd_chk("warn", `ADDR_WARN_FLAGS, {3'h0, stat[10:6]});
      rd_chk("mask", `ADDR_PIN_MASK, m);
    end
    $display("test status and pins done");
    // ac setup: both lengths and both legal current codes
    for (int i = 0; i < 8; i++)
    begin
      d = 8'($random(seed));
      m = {d[7:5], i[0], 1'b0, i[1], d[1:0]};
      hm.wr(`ADDR_AC_ENABLE_GAIN, d);
      hm.wr(`ADDR_AC_MEASURE_LENGTH_SEL_CURRENT, m);
      rd_chk("acen", `ADDR_AC_ENABLE_GAIN, d & 8'haf);
      rd_chk("actc", `ADDR_AC_MEASURE_LENGTH_SEL_CURRENT, m & 8'h9c);
      chk_reg("acen_out", {d[7], 1'b0, d[5], 1'b0, d[3:0]}, {g12, 1'b0, g34, 1'b0, ac_en});
      chk_reg("actc_out", {m[7], 2'h0, m[4], m[3:2], 2'h0}, {lb, 2'h0, len, cur, 2'h0});
      chk_reg("cycles", m[4] ? 8'h40 : 8'h20, {1'b0, cyc});
    end
    $display("test ac setup done");
    // second reset in mid-run restores the defaults
    @(posedge core_clk);
    rst <= 1'b1;
    stat <= 16'h0000;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rd_chk("warn_rst2", `ADDR_WARN_FLAGS, 8'h20);
    rd_chk("acen_rst2", `ADDR_AC_ENABLE_GAIN, 8'h00);
    rd_chk("mask_rst2", `ADDR_PIN_MASK, 8'h00);
    rd_chk("actc_rst2", `ADDR_AC_MEASURE_LENGTH_SEL_CURRENT, 8'h00);
    chk_pin("fault_rst2", 1'b1, fault_alert_n);
    chk_pin("warn_rst2", 1'b1, warn_alert_n);
    $display("test second reset done");
    give_verdict();
  end
endmodule

`default_nettype wire
